// ### shared/tca_consts.svh
// Constants of the time, calendar and alarm core.
// Assumes inclusion by bare name from package and design files.
`ifndef TCA_CONSTS_SVH
`define TCA_CONSTS_SVH

// Timebase
`define TCA_CLK_HZ        200_000_000
`define TCA_TICK_HZ       100
`define TCA_TICK_CYCLES   (`TCA_CLK_HZ / `TCA_TICK_HZ)

// Register indices, byte address is four times the index
`define TCA_IDX_HS        6'h00
`define TCA_IDX_SEC       6'h01
`define TCA_IDX_MIN       6'h02
`define TCA_IDX_HOUR      6'h03
`define TCA_IDX_WDAY      6'h04
`define TCA_IDX_DATE      6'h05
`define TCA_IDX_MON       6'h06
`define TCA_IDX_YEAR      6'h07
`define TCA_IDX_AMIN      6'h08
`define TCA_IDX_AHOUR     6'h09
`define TCA_IDX_AWD       6'h0A
`define TCA_IDX_CTRL      6'h0B

// Writable bit masks, other bits are fixed zero
`define TCA_MSK_SEC       8'h7F
`define TCA_MSK_MIN       8'h7F
`define TCA_MSK_HOUR      8'h3F
`define TCA_MSK_WDAY      8'h7F
`define TCA_MSK_DATE      8'h3F
`define TCA_MSK_MON       8'h1F
`define TCA_MSK_YEAR      8'hFF
`define TCA_MSK_ALM       8'hFF
`define TCA_MSK_CTRL      8'h07

// BCD limits and calendar values
`define TCA_ZERO          8'h00
`define TCA_ONE           8'h01
`define TCA_HS_LAST       8'h99
`define TCA_SEC_LAST      8'h59
`define TCA_MIN_LAST      8'h59
`define TCA_HOUR_LAST     8'h23
`define TCA_MON_LAST      8'h12
`define TCA_YEAR_LAST     8'h99
`define TCA_WDAY_LAST     8'h40
`define TCA_D31           8'h31
`define TCA_D30           8'h30
`define TCA_D29           8'h29
`define TCA_D28           8'h28
`define TCA_FEB           8'h02
`define TCA_APR           8'h04
`define TCA_JUN           8'h06
`define TCA_SEP           8'h09
`define TCA_NOV           8'h11
`define TCA_NINE          4'h9
`define TCA_NIB_ZERO      4'h0
`define TCA_LEAP_REM      2'h0

// Reset values
`define TCA_RST_WDAY      8'h01
`define TCA_RST_DATE      8'h01
`define TCA_RST_MON       8'h01
`define TCA_RST_YEAR      8'h01
`define TCA_RST_ALM       8'h80
`define TCA_RST_IEN       1'b1

// Field positions
`define TCA_ALM_MASK_BIT  7
`define TCA_CTL_SEL_BIT   0
`define TCA_CTL_FLAG_BIT  1
`define TCA_CTL_IEN_BIT   2
`define TCA_CTL_RSTC_BIT  3
`define TCA_TGT_DATE      1'b1

`endif

// ### shared/tca_pkg.sv
// Types of the time, calendar and alarm core.
// Assumes tca_consts.svh on the include path.
`include "tca_consts.svh"

package tca_pkg;
  typedef logic [7:0] tca_bcd_t;
  typedef logic [5:0] tca_idx_t;
endpackage

// ### shared/tca_alarm_if.sv
// Link between the counter core and the alarm comparator.
// Assumes both ends run on the same clock.
`timescale 1ns/10ps
`default_nettype none

interface tca_alarm_if;
  import tca_pkg::*;
  tca_bcd_t cur_min;
  tca_bcd_t cur_hour;
  tca_bcd_t cur_wday;
  tca_bcd_t cur_date;
  tca_bcd_t alm_min;
  tca_bcd_t alm_hour;
  tca_bcd_t alm_wd;
  logic     tgt_date;
  logic     match;
  modport core (output cur_min, cur_hour, cur_wday, cur_date, alm_min, alm_hour, alm_wd,
                output tgt_date, input match);
  modport cmp  (input cur_min, cur_hour, cur_wday, cur_date, alm_min, alm_hour, alm_wd,
                input tgt_date, output match);
endinterface

`default_nettype wire

// ### src/tca_alarm_cmp.sv
// Alarm comparator: registered match of alarm settings against current time.
// Assumes clock, reset and enable shared with the counter core.
`timescale 1ns/10ps
`default_nettype none
`include "tca_consts.svh"

module tca_alarm_cmp
  import tca_pkg::*;
(
  input  wire logic clk_i,
  input  wire logic nrst_i,
  input  wire logic ce_i,
  tca_alarm_if.cmp  al
);
  logic match_d;
  logic match_q;

  always_comb
  begin
    logic m_min;
    logic m_hour;
    logic m_wd;
    m_wd   = 1'b0;
    m_min  = al.alm_min[`TCA_ALM_MASK_BIT]  || (al.alm_min[6:0] == al.cur_min[6:0]); // see [RULE24]
    m_hour = al.alm_hour[`TCA_ALM_MASK_BIT] || (al.alm_hour[5:0] == al.cur_hour[5:0]);
    if (al.alm_wd[`TCA_ALM_MASK_BIT])
    begin
      m_wd = 1'b1;
    end
    else if (al.tgt_date == `TCA_TGT_DATE) // see [RULE20]
    begin
      m_wd = (al.alm_wd[5:0] == al.cur_date[5:0]);
    end
    else
    begin
      m_wd = |(al.alm_wd[6:0] & al.cur_wday[6:0]);
    end
    match_d = m_min && m_hour && m_wd; // see [RULE17]
  end

  always_ff @(posedge clk_i)
  begin
    if (!nrst_i)
    begin
      match_q <= 1'b1;
    end
    else if (ce_i)
    begin
      match_q <= match_d;
    end
  end

  assign al.match = match_q;
endmodule

`default_nettype wire

// ### src/tca_core.sv
// Time, calendar and alarm core with an APB register slave.
// Assumes a free-running clk_i at 200 MHz and an APB master on the same clock.
// Notes on behaviour
// [RULE1] All time and date counters hold packed BCD, tens high, units low.
// [RULE2] Hundredths count 00 to 99, then back to 00.
// [RULE3] Seconds count 00 to 59, then back to 00.
// [RULE4] Minutes count 00 to 59, then back to 00.
// [RULE5] Hours count 00 to 23 in 24-hour form, then back to 00.
// [RULE6] Fixed-zero bits ignore writes and read as zero.
// [RULE7] Weekday is one-hot in bits 0 to 6, Sunday 01h to Saturday 40h.
// [RULE8] Date, month and year update automatically from 2000 through 2099.
// [RULE9] Date holds two BCD digits, 31 reads as 0011 0001.
// [RULE10] Months 1,3,5,7,8,10,12: date runs 01 to 31, wraps to 01.
// [RULE11] Months 4,6,9,11: date runs 01 to 30, wraps to 01.
// [RULE12] February of a common year: date wraps from 28 to 01.
// [RULE13] February of a leap year: date counts 28, 29, then 01.
// [RULE14] Any year divisible by four is a leap year, no century exception.
// [RULE15] Month counts 01 to 12, then back to 01.
// [RULE16] Year counts 00 to 99, then back to 00.
// [RULE17] Alarm match drives the interrupt low and sets the alarm flag.
// [RULE18] Host writes only valid time values.
// [RULE19] Host writes only valid dates and one-hot weekday codes.
// [RULE20] Target select 1 compares date, 0 compares weekday.
// [RULE21] Alarm flag stays set until host writes zero; writing one does nothing.
// [RULE22] Seconds write or reset command clears hundredths to 00.
// [RULE23] Each counter steps when the lower one wraps; hundredths step at 100 Hz.
// [RULE24] Bit 7 of each alarm register removes that field from the match.
// [RULE25] Hundredths register is read-only; writes are ignored.
`timescale 1ns/10ps
`default_nettype none
`include "tca_consts.svh"

module tca_core
  import tca_pkg::*;
#(
  parameter int TICK_CYCLES = `TCA_TICK_CYCLES
)
(
  input  wire logic        clk_i,
  input  wire logic        nrst_i,
  input  wire logic        ce_i,
  input  wire logic        psel_i,
  input  wire logic        penable_i,
  input  wire logic        pwrite_i,
  input  wire logic [7:0]  paddr_i,
  input  wire logic [31:0] pwdata_i,
  input  wire logic [3:0]  pstrb_i,
  output logic      [31:0] prdata_o,
  output logic             pready_o,
  output logic             pslverr_o,
  output logic             int_n_o
);
  localparam int TW = (TICK_CYCLES > 1) ? $clog2(TICK_CYCLES) : 1;

  // BCD step with wrap to a given first value
  function automatic tca_bcd_t bcd_inc(input tca_bcd_t v, input tca_bcd_t last,
                                       input tca_bcd_t first);
    if (v == last)
    begin
      return first;
    end
    else if (v[3:0] == `TCA_NINE)
    begin
      return {4'(v[7:4] + 4'h1), `TCA_NIB_ZERO}; // see [RULE1]
    end
    else
    begin
      return 8'(v + 8'h01);
    end
  endfunction

  // Year divisible by four: (2*tens + units) mod 4
  function automatic logic is_leap(input tca_bcd_t y);
    return 2'({y[4], 1'b0} + y[1:0]) == `TCA_LEAP_REM; // see [RULE14]
  endfunction

  function automatic tca_bcd_t last_day(input tca_bcd_t m, input tca_bcd_t y);
    if (m == `TCA_FEB)
    begin
      return is_leap(y) ? `TCA_D29 : `TCA_D28; // see [RULE12] see [RULE13]
    end
    else if (m == `TCA_APR || m == `TCA_JUN || m == `TCA_SEP || m == `TCA_NOV)
    begin
      return `TCA_D30; // see [RULE11]
    end
    else
    begin
      return `TCA_D31; // see [RULE10]
    end
  endfunction

  function automatic logic idx_mapped(input tca_idx_t i);
    return i <= `TCA_IDX_CTRL;
  endfunction

  tca_bcd_t       hs_q, hs_d, sec_q, sec_d, min_q, min_d, hour_q, hour_d;
  tca_bcd_t       wday_q, wday_d, date_q, date_d, mon_q, mon_d, year_q, year_d;
  tca_bcd_t       amin_q, amin_d, ahour_q, ahour_d, awd_q, awd_d;
  logic [TW-1:0]  tick_cnt_q, tick_cnt_d;
  logic           sel_q, sel_d, flag_q, flag_d, ien_q, ien_d;
  logic           match_prev_q, int_n_q, int_n_d;
  logic           rd_valid_q, rd_valid_d;
  logic [31:0]    rdata_q, rdata_d;
  logic           tick, c_hs, c_sec, c_min, c_hour, c_date, c_mon;
  logic           done, wr_en, alarm_rise, rst_cmd, aligned;
  tca_idx_t       idx;
  tca_bcd_t       rd_byte;

  tca_alarm_if al ();

  tca_alarm_cmp u_cmp (
    .clk_i  (clk_i),
    .nrst_i (nrst_i),
    .ce_i   (ce_i),
    .al     (al)
  );

  assign al.cur_min  = min_q;
  assign al.cur_hour = hour_q;
  assign al.cur_wday = wday_q;
  assign al.cur_date = date_q;
  assign al.alm_min  = amin_q;
  assign al.alm_hour = ahour_q;
  assign al.alm_wd   = awd_q;
  assign al.tgt_date = sel_q;

  // Bus decode
  assign idx     = paddr_i[7:2];
  assign aligned = (paddr_i[1:0] == 2'b00);
  assign done    = psel_i && penable_i && rd_valid_q;
  assign wr_en   = done && pwrite_i && pstrb_i[0] && aligned && idx_mapped(idx);
  assign rst_cmd = wr_en && (idx == `TCA_IDX_CTRL) && pwdata_i[`TCA_CTL_RSTC_BIT];

  assign pready_o  = done && ce_i;
  assign pslverr_o = done && ce_i && !(aligned && idx_mapped(idx));
  assign prdata_o  = rdata_q;
  assign int_n_o   = int_n_q;

  // Carry chain
  assign tick   = (tick_cnt_q == TW'(TICK_CYCLES - 1)); // see [RULE23]
  assign c_hs   = tick && (hs_q == `TCA_HS_LAST);
  assign c_sec  = c_hs && (sec_q == `TCA_SEC_LAST);
  assign c_min  = c_sec && (min_q == `TCA_MIN_LAST);
  assign c_hour = c_min && (hour_q == `TCA_HOUR_LAST);
  assign c_date = c_hour && (date_q == last_day(mon_q, year_q));
  assign c_mon  = c_date && (mon_q == `TCA_MON_LAST);

  assign alarm_rise = al.match && !match_prev_q;

  // Read multiplexer, fixed-zero bits come back as zero
  always_comb
  begin
    case (idx)
      `TCA_IDX_HS:    rd_byte = hs_q;
      `TCA_IDX_SEC:   rd_byte = sec_q & `TCA_MSK_SEC; // see [RULE6]
      `TCA_IDX_MIN:   rd_byte = min_q & `TCA_MSK_MIN;
      `TCA_IDX_HOUR:  rd_byte = hour_q & `TCA_MSK_HOUR;
      `TCA_IDX_WDAY:  rd_byte = wday_q & `TCA_MSK_WDAY;
      `TCA_IDX_DATE:  rd_byte = date_q & `TCA_MSK_DATE;
      `TCA_IDX_MON:   rd_byte = mon_q & `TCA_MSK_MON;
      `TCA_IDX_YEAR:  rd_byte = year_q;
      `TCA_IDX_AMIN:  rd_byte = amin_q;
      `TCA_IDX_AHOUR: rd_byte = ahour_q;
      `TCA_IDX_AWD:   rd_byte = awd_q;
      `TCA_IDX_CTRL:  rd_byte = {5'h00, ien_q, flag_q, sel_q};
      default:        rd_byte = `TCA_ZERO;
    endcase
  end

  // Read capture and access completion
  always_comb
  begin
    rd_valid_d = rd_valid_q;
    rdata_d    = rdata_q;
    if (done)
    begin
      rd_valid_d = 1'b0;
    end
    else if (psel_i)
    begin
      rd_valid_d = 1'b1;
      rdata_d    = {24'h00_0000, (aligned ? rd_byte : `TCA_ZERO)};
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (!nrst_i)
    begin
      rd_valid_q <= 1'b0;
      rdata_q    <= 32'h0000_0000;
    end
    else if (ce_i)
    begin
      rd_valid_q <= rd_valid_d;
      rdata_q    <= rdata_d;
    end
  end

  // Counters, alarm settings, control and flag
  always_comb
  begin
    tick_cnt_d = tick ? '0 : TW'(tick_cnt_q + 1'b1);
    hs_d    = tick   ? bcd_inc(hs_q, `TCA_HS_LAST, `TCA_ZERO) : hs_q; // see [RULE2]
    sec_d   = c_hs   ? bcd_inc(sec_q, `TCA_SEC_LAST, `TCA_ZERO) : sec_q; // see [RULE3]
    min_d   = c_sec  ? bcd_inc(min_q, `TCA_MIN_LAST, `TCA_ZERO) : min_q; // see [RULE4]
    hour_d  = c_min  ? bcd_inc(hour_q, `TCA_HOUR_LAST, `TCA_ZERO) : hour_q; // see [RULE5]
    wday_d  = c_hour ? ((wday_q == `TCA_WDAY_LAST) ? `TCA_ONE : 8'(wday_q << 1)) : wday_q; // see [RULE7]
    date_d  = c_hour ? bcd_inc(date_q, last_day(mon_q, year_q), `TCA_ONE) : date_q; // see [RULE9]
    mon_d   = c_date ? bcd_inc(mon_q, `TCA_MON_LAST, `TCA_ONE) : mon_q; // see [RULE15]
    year_d  = c_mon  ? bcd_inc(year_q, `TCA_YEAR_LAST, `TCA_ZERO) : year_q; // see [RULE16] see [RULE8]
    amin_d  = amin_q;
    ahour_d = ahour_q;
    awd_d   = awd_q;
    sel_d   = sel_q;
    ien_d   = ien_q;
    flag_d  = flag_q;
    if (wr_en)
    begin
      case (idx)
        `TCA_IDX_SEC:
        begin
          sec_d      = pwdata_i[7:0] & `TCA_MSK_SEC; // see [RULE6]
          hs_d       = `TCA_ZERO; // see [RULE22]
          tick_cnt_d = '0;
        end
        `TCA_IDX_MIN:   min_d   = pwdata_i[7:0] & `TCA_MSK_MIN;
        `TCA_IDX_HOUR:  hour_d  = pwdata_i[7:0] & `TCA_MSK_HOUR;
        `TCA_IDX_WDAY:  wday_d  = pwdata_i[7:0] & `TCA_MSK_WDAY;
        `TCA_IDX_DATE:  date_d  = pwdata_i[7:0] & `TCA_MSK_DATE;
        `TCA_IDX_MON:   mon_d   = pwdata_i[7:0] & `TCA_MSK_MON;
        `TCA_IDX_YEAR:  year_d  = pwdata_i[7:0] & `TCA_MSK_YEAR;
        `TCA_IDX_AMIN:  amin_d  = pwdata_i[7:0] & `TCA_MSK_ALM;
        `TCA_IDX_AHOUR: ahour_d = pwdata_i[7:0] & `TCA_MSK_ALM;
        `TCA_IDX_AWD:   awd_d   = pwdata_i[7:0] & `TCA_MSK_ALM;
        `TCA_IDX_CTRL:
        begin
          sel_d = pwdata_i[`TCA_CTL_SEL_BIT];
          ien_d = pwdata_i[`TCA_CTL_IEN_BIT];
          if (!pwdata_i[`TCA_CTL_FLAG_BIT])
          begin
            flag_d = 1'b0; // see [RULE21]
          end
        end
        default:
        begin
          // Hundredths register is read-only
          hs_d = hs_d; // see [RULE25]
        end
      endcase
    end
    if (rst_cmd)
    begin
      hs_d       = `TCA_ZERO; // see [RULE22]
      tick_cnt_d = '0;
    end
    if (alarm_rise)
    begin
      flag_d = 1'b1; // see [RULE17]
    end
    int_n_d = !(flag_d && ien_d);
  end

  always_ff @(posedge clk_i)
  begin
    if (!nrst_i)
    begin
      tick_cnt_q   <= '0;
      hs_q         <= `TCA_ZERO;
      sec_q        <= `TCA_ZERO;
      min_q        <= `TCA_ZERO;
      hour_q       <= `TCA_ZERO;
      wday_q       <= `TCA_RST_WDAY;
      date_q       <= `TCA_RST_DATE;
      mon_q        <= `TCA_RST_MON;
      year_q       <= `TCA_RST_YEAR;
      amin_q       <= `TCA_RST_ALM;
      ahour_q      <= `TCA_RST_ALM;
      awd_q        <= `TCA_RST_ALM;
      sel_q        <= 1'b0;
      ien_q        <= `TCA_RST_IEN;
      flag_q       <= 1'b0;
      match_prev_q <= 1'b1;
      int_n_q      <= 1'b1;
    end
    else if (ce_i)
    begin
      tick_cnt_q   <= tick_cnt_d;
      hs_q         <= hs_d;
      sec_q        <= sec_d;
      min_q        <= min_d;
      hour_q       <= hour_d;
      wday_q       <= wday_d;
      date_q       <= date_d;
      mon_q        <= mon_d;
      year_q       <= year_d;
      amin_q       <= amin_d;
      ahour_q      <= ahour_d;
      awd_q        <= awd_d;
      sel_q        <= sel_d;
      ien_q        <= ien_d;
      flag_q       <= flag_d;
      match_prev_q <= al.match;
      int_n_q      <= int_n_d;
    end
  end

  property p_hs_wrap; // see [RULE2]
    @(posedge clk_i) disable iff (!nrst_i)
      ce_i && tick && hs_q == `TCA_HS_LAST && !wr_en |=> hs_q == `TCA_ZERO && sec_q != $past(sec_q);
  endproperty
  a_hs_wrap: assert property (p_hs_wrap) else $error("hundredths did not wrap with carry");

  property p_sec_wrap; // see [RULE3]
    @(posedge clk_i) disable iff (!nrst_i)
      ce_i && c_sec && !wr_en |=> sec_q == `TCA_ZERO;
  endproperty
  a_sec_wrap: assert property (p_sec_wrap) else $error("seconds did not wrap at 59");

  property p_hour_wrap; // see [RULE5]
    @(posedge clk_i) disable iff (!nrst_i)
      ce_i && c_hour && !wr_en |=> hour_q == `TCA_ZERO && date_q != $past(date_q);
  endproperty
  a_hour_wrap: assert property (p_hour_wrap) else $error("hours did not wrap at 23");

  property p_wday_rot; // see [RULE7]
    @(posedge clk_i) disable iff (!nrst_i)
      ce_i && c_hour && !wr_en && wday_q == `TCA_WDAY_LAST |=> wday_q == `TCA_ONE;
  endproperty
  a_wday_rot: assert property (p_wday_rot) else $error("weekday did not return to Sunday");

  property p_feb_common; // see [RULE12]
    @(posedge clk_i) disable iff (!nrst_i)
      ce_i && c_hour && !wr_en && mon_q == `TCA_FEB && date_q == `TCA_D28 && !is_leap(year_q)
      |=> date_q == `TCA_ONE && mon_q == 8'h03;
  endproperty
  a_feb_common: assert property (p_feb_common) else $error("common February did not end at 28");

  property p_feb_leap; // see [RULE13]
    @(posedge clk_i) disable iff (!nrst_i)
      ce_i && c_hour && !wr_en && mon_q == `TCA_FEB && date_q == `TCA_D28 && is_leap(year_q)
      |=> date_q == `TCA_D29 && mon_q == `TCA_FEB;
  endproperty
  a_feb_leap: assert property (p_feb_leap) else $error("leap February skipped the 29th");

  property p_flag_hold; // see [RULE21]
    @(posedge clk_i) disable iff (!nrst_i)
      flag_q && !(wr_en && idx == `TCA_IDX_CTRL && !pwdata_i[`TCA_CTL_FLAG_BIT]) |=> flag_q;
  endproperty
  a_flag_hold: assert property (p_flag_hold) else $error("alarm flag dropped without a clear");

  property p_alarm_int; // see [RULE17]
    @(posedge clk_i) disable iff (!nrst_i)
      ce_i && al.match && !match_prev_q && ien_q && !(wr_en && idx == `TCA_IDX_CTRL)
      |=> flag_q && !int_n_o;
  endproperty
  a_alarm_int: assert property (p_alarm_int) else $error("alarm match did not raise flag and int");

  property p_sec_clears_hs; // see [RULE22]
    @(posedge clk_i) disable iff (!nrst_i)
      ce_i && wr_en && idx == `TCA_IDX_SEC |=> hs_q == `TCA_ZERO && tick_cnt_q == '0;
  endproperty
  a_sec_clears_hs: assert property (p_sec_clears_hs) else $error("seconds write kept hundredths");

  property p_sec_zero_bit; // see [RULE6]
    @(posedge clk_i) disable iff (!nrst_i)
      ce_i && psel_i && !rd_valid_q && aligned && idx == `TCA_IDX_SEC |=> prdata_o[31:7] == '0;
  endproperty
  a_sec_zero_bit: assert property (p_sec_zero_bit) else $error("fixed-zero bit read as one");

  property p_hs_ro; // see [RULE25]
    @(posedge clk_i) disable iff (!nrst_i)
      ce_i && wr_en && idx == `TCA_IDX_HS && !tick |=> hs_q == $past(hs_q);
  endproperty
  a_hs_ro: assert property (p_hs_ro) else $error("hundredths changed on a write");
endmodule

`default_nettype wire

// ### dv/tca_host_model.sv
// Host side of the register bus: APB master, one transfer at a time.
// Assumes the slave shares clk_i; the bench calls xfer hierarchically.
`timescale 1ns/10ps
`default_nettype none

module tca_host_model
(
  input  wire logic        clk_i,
  output logic             psel_o,
  output logic             penable_o,
  output logic             pwrite_o,
  output logic      [7:0]  paddr_o,
  output logic      [31:0] pwdata_o,
  output logic      [3:0]  pstrb_o,
  input  wire logic [31:0] prdata_i,
  input  wire logic        pready_i,
  input  wire logic        pslverr_i
);
  initial
  begin
    psel_o    = 1'b0;
    penable_o = 1'b0;
    pwrite_o  = 1'b0;
    paddr_o   = 8'h00;
    pwdata_o  = 32'h0000_0000;
    pstrb_o   = 4'h0;
  end

  // Callers hand over valid times, dates and one-hot weekdays, except t_fixed_zero, which also sets fixed-zero bits
  task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] q, output logic err);
    @(posedge clk_i);
    psel_o   <= 1'b1;
    pwrite_o <= wr;
    paddr_o  <= a;
    pwdata_o <= d;
    pstrb_o  <= 4'hF;
    @(posedge clk_i);
    penable_o <= 1'b1;
    forever
    begin
      @(posedge clk_i);
      if (pready_i === 1'b1)
        break;
    end
    q   = prdata_i;
    err = pslverr_i;
    // Released bus shows no stale values
    psel_o    <= 1'b0;
    penable_o <= 1'b0;
    pwrite_o  <= ~wr;
    paddr_o   <= ~a;
    pwdata_o  <= ~d;
    pstrb_o   <= 4'h0;
  endtask
endmodule

`default_nettype wire

// ### dv/testbench.sv
// Self-checking bench for the time, calendar and alarm core.
// Assumes the host model drives the APB port; short prescaler for speed.
`timescale 1ns/10ps
`default_nettype none
`include "tca_consts.svh"

module testbench;
  import tca_pkg::*;
  localparam int TICKS = 4;
  localparam int LIMIT = 20000;
  logic        clk_i;
  logic        nrst_i;
  logic        ce_i;
  logic        psel, penable, pwrite, pready, pslverr, int_n;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata;
  logic [3:0]  pstrb;
  int          num_errors, checks, cycles;

  tca_core #(.TICK_CYCLES(TICKS)) dut_u (.clk_i(clk_i), .nrst_i(nrst_i), .ce_i(ce_i),
    .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr),
    .pwdata_i(pwdata), .pstrb_i(pstrb), .prdata_o(prdata), .pready_o(pready),
    .pslverr_o(pslverr), .int_n_o(int_n));

  tca_host_model host_u (.clk_i(clk_i), .psel_o(psel), .penable_o(penable),
    .pwrite_o(pwrite), .paddr_o(paddr), .pwdata_o(pwdata), .pstrb_o(pstrb),
    .prdata_i(prdata), .pready_i(pready), .pslverr_i(pslverr));

  initial clk_i = 1'b0;
  always #2.5 clk_i = ~clk_i;

  always @(posedge clk_i)
  begin
    cycles++;
    if (cycles == LIMIT)
    begin
      num_errors++;
      results();
    end
  end

  task automatic results;
    $display("checks %0d errors %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  task automatic chk(input string n, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("[FAIL] %s expected %h seen %h", n, exp, seen);
    end
  endtask

  task automatic wr(input tca_idx_t i, input logic [7:0] d);
    logic [31:0] q;
    logic        e;
    host_u.xfer(1'b1, {i, 2'b00}, {24'h00_0000, d}, q, e);
  endtask

  task automatic rd(input tca_idx_t i, input logic [7:0] e, input string n);
    logic [31:0] q;
    logic        er;
    host_u.xfer(1'b0, {i, 2'b00}, 32'h0000_0000, q, er);
    chk(n, q, {24'h00_0000, e});
  endtask

  task automatic do_reset;
    nrst_i <= 1'b0;
    repeat (12) @(posedge clk_i);
    nrst_i <= 1'b1;
  endtask

  task automatic t_reset_values;
    logic [31:0] q;
    logic        er;
    rd(`TCA_IDX_SEC, `TCA_ZERO, "sec_rst");
    rd(`TCA_IDX_MIN, `TCA_ZERO, "min_rst");
    rd(`TCA_IDX_HOUR, `TCA_ZERO, "hour_rst");
    rd(`TCA_IDX_WDAY, 8'h01, "wday_rst");
    rd(`TCA_IDX_YEAR, 8'h01, "year_rst");
    rd(`TCA_IDX_AMIN, 8'h80, "amin_rst");
    rd(`TCA_IDX_AWD, 8'h80, "awd_rst");
    rd(`TCA_IDX_CTRL, 8'h04, "ctrl_rst");
    chk("int_rst", {31'h0000_0000, int_n}, 32'h0000_0001);
    host_u.xfer(1'b0, 8'h30, 32'h0000_0000, q, er);
    chk("unmapped_err", {31'h0000_0000, er}, 32'h0000_0001);
    chk("unmapped_data", q, 32'h0000_0000);
  endtask

  task automatic t_fixed_zero;
    tca_idx_t    idx[6] = '{`TCA_IDX_SEC, `TCA_IDX_MIN, `TCA_IDX_HOUR, `TCA_IDX_WDAY,
                            `TCA_IDX_DATE, `TCA_IDX_MON};
    logic [7:0]  msk[6] = '{`TCA_MSK_SEC, `TCA_MSK_MIN, `TCA_MSK_HOUR, `TCA_MSK_WDAY,
                            `TCA_MSK_DATE, `TCA_MSK_MON};
    logic [7:0]  wv[6]  = '{8'hD9, 8'hD9, 8'hE3, 8'hC0, 8'hF1, 8'hF2};
    logic [31:0] q;
    logic        er;
    wr(`TCA_IDX_HS, 8'h55);
    host_u.xfer(1'b0, 8'h00, 32'h0000_0000, q, er);
    chk("hs_write_ignored", {31'h0000_0000, q[7:0] < 8'h10}, 32'h0000_0001);
    for (int k = 0; k < 6; k++)
    begin
      wr(idx[k], wv[k]);
      rd(idx[k], wv[k] & msk[k], "fixed_zero");
    end
    do_reset();
  endtask

  task automatic t_hs_clear;
    logic [31:0] q;
    logic        er;
    wr(`TCA_IDX_SEC, 8'h10);
    repeat (200) @(posedge clk_i);
    host_u.xfer(1'b0, 8'h00, 32'h0000_0000, q, er);
    chk("hs_running", {31'h0000_0000, q[7:0] != 8'h00}, 32'h0000_0001);
    wr(`TCA_IDX_SEC, 8'h10);
    rd(`TCA_IDX_HS, `TCA_ZERO, "hs_sec_write");
    repeat (200) @(posedge clk_i);
    wr(`TCA_IDX_CTRL, 8'h0C);
    rd(`TCA_IDX_HS, `TCA_ZERO, "hs_reset_cmd");
    // Enable low freezes the prescaler: one tick only after 40 frozen cycles
    ce_i <= 1'b0;
    repeat (40) @(posedge clk_i);
    ce_i <= 1'b1;
    rd(`TCA_IDX_HS, 8'h01, "hs_frozen");
  endtask

  // One day boundary crossed from 23:59:59 on Saturday
  task automatic day_roll(input logic [7:0] m, d, y, ed, em, ey);
    wr(`TCA_IDX_YEAR, y);
    wr(`TCA_IDX_DATE, d);
    wr(`TCA_IDX_MON, m);
    wr(`TCA_IDX_WDAY, 8'h40);
    wr(`TCA_IDX_HOUR, 8'h23);
    wr(`TCA_IDX_MIN, 8'h59);
    wr(`TCA_IDX_SEC, 8'h59);
    repeat (TICKS * 100 - 40) @(posedge clk_i);
    rd(`TCA_IDX_SEC, 8'h59, "sec_before_wrap");
    repeat (60) @(posedge clk_i);
    rd(`TCA_IDX_SEC, `TCA_ZERO, "sec_wrap");
    rd(`TCA_IDX_MIN, `TCA_ZERO, "min_wrap");
    rd(`TCA_IDX_HOUR, `TCA_ZERO, "hour_wrap");
    rd(`TCA_IDX_WDAY, 8'h01, "wday_wrap");
    rd(`TCA_IDX_DATE, ed, "date_next");
    rd(`TCA_IDX_MON, em, "month_next");
    rd(`TCA_IDX_YEAR, ey, "year_next");
  endtask

  task automatic t_calendar;
    day_roll(8'h12, 8'h31, 8'h99, 8'h01, 8'h01, 8'h00);
    day_roll(8'h01, 8'h09, 8'h01, 8'h10, 8'h01, 8'h01);
    day_roll(8'h01, 8'h30, 8'h01, 8'h31, 8'h01, 8'h01);
    day_roll(8'h04, 8'h30, 8'h01, 8'h01, 8'h05, 8'h01);
    day_roll(8'h02, 8'h28, 8'h01, 8'h01, 8'h03, 8'h01);
    day_roll(8'h02, 8'h28, 8'h04, 8'h29, 8'h02, 8'h04);
    day_roll(8'h02, 8'h29, 8'h04, 8'h01, 8'h03, 8'h04);
    day_roll(8'h02, 8'h28, 8'h00, 8'h29, 8'h02, 8'h00);
  endtask

  // Minute alarm 01, hour field masked, date or weekday field 02
  task automatic t_alarm(input logic tgt, input logic fire);
    do_reset();
    wr(`TCA_IDX_WDAY, 8'h01);
    wr(`TCA_IDX_DATE, 8'h02);
    wr(`TCA_IDX_AMIN, 8'h01);
    wr(`TCA_IDX_AHOUR, 8'h85);
    wr(`TCA_IDX_AWD, 8'h02);
    wr(`TCA_IDX_CTRL, {7'h02, tgt});
    wr(`TCA_IDX_SEC, 8'h59);
    repeat (TICKS * 100 + 20) @(posedge clk_i);
    chk("int_alarm", {31'h0000_0000, int_n}, {31'h0000_0000, ~fire});
    rd(`TCA_IDX_CTRL, {6'h01, fire, tgt}, "flag_alarm");
    wr(`TCA_IDX_CTRL, {7'h03, tgt});
    rd(`TCA_IDX_CTRL, {6'h01, fire, tgt}, "flag_write_one");
    wr(`TCA_IDX_CTRL, {7'h02, tgt});
    rd(`TCA_IDX_CTRL, {7'h02, tgt}, "flag_cleared");
    chk("int_cleared", {31'h0000_0000, int_n}, 32'h0000_0001);
  endtask

  initial
  begin
    nrst_i     = 1'b0;
    ce_i       = 1'b1;
    num_errors = 0;
    checks     = 0;
    cycles     = 0;
    repeat (12) @(posedge clk_i);
    nrst_i <= 1'b1;
    t_reset_values();
    t_fixed_zero();
    t_hs_clear();
    t_calendar();
    t_alarm(1'b1, 1'b1);
    t_alarm(1'b0, 1'b0);
    results();
  end
endmodule

`default_nettype wire
